// ### logic/wwdt_pkg.sv
/*
  Package for the windowed watchdog timer: register map, field layout,
  reset values and timing constants.
  Assumes a 40 MHz system clock standing in for the machine-cycle clock.
*/
`default_nettype none
package wwdt_pkg;
  // ==========================================================
  // register map
  // ctrl offset is a word index; opt and stat are byte addresses
  localparam logic [7:0] WWDT_CTRL_INDEX = 8'h2e;
  localparam logic [7:0] WWDT_CTRL_ADDR = {WWDT_CTRL_INDEX[5:0], 2'h0};
  localparam logic [7:0] WWDT_OPT_ADDR = 8'h30;
  localparam logic [7:0] WWDT_STAT_ADDR = 8'h34;
  localparam int WWDT_ARM_BIT = 7;
  localparam int WWDT_TOP_BIT = 6;
  localparam logic [7:0] WWDT_CTRL_RESET = 8'h7f;
  localparam logic [6:0] WWDT_ROLL_FROM = 7'h40;
  // ==========================================================
  // timing
  localparam int WWDT_STEP_CYCLES = 16000;
  localparam int WWDT_STEPS = 64;
  localparam int WWDT_RST_PHASE_SHORT = 256;
  localparam int WWDT_RST_PHASE_LONG = 4096;
  localparam int WWDT_CLK_MHZ = 40;
  localparam int WWDT_PULSE_NS = 30000;
  localparam int WWDT_PULSE_CYCLES = (WWDT_PULSE_NS * WWDT_CLK_MHZ) / 1000;
  // ==========================================================
  // bus answers
  localparam logic [1:0] WWDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WWDT_RESP_SLVERR = 2'h2;
endpackage : wwdt_pkg
`default_nettype wire

// ### logic/wwdt_wr_if.sv
/*
  Write carrier between the bus slave and the watchdog core.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface wwdt_wr_if;
  logic ctrl_we;
  logic opt_we;
  logic [7:0] wdata;
  modport src (output ctrl_we, output opt_we, output wdata);
  modport dst (input ctrl_we, input opt_we, input wdata);
endinterface : wwdt_wr_if
`default_nettype wire

// ### logic/wwdt_axil.sv
/*
  AXI4-Lite slave for the watchdog registers.
  Assumes one write and one read outstanding at most.
*/
`timescale 1ns/1ps
`default_nettype none
module wwdt_axil (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] ctrl_rd,
  input wire logic [7:0] opt_rd,
  input wire logic [7:0] stat_rd,
  wwdt_wr_if.src wr
);
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic fire;

  // ==========================================================
  // write channel
  assign awready = !aw_have_q && !bvalid;
  assign wready = !w_have_q && !bvalid;
  assign fire = aw_have_q && w_have_q && !bvalid;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (fire) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= wwdt_pkg::WWDT_RESP_OKAY;
    end else if (fire) begin
      bvalid <= 1'b1;
      bresp <= (awaddr_q == wwdt_pkg::WWDT_CTRL_ADDR || awaddr_q == wwdt_pkg::WWDT_OPT_ADDR)
               ? wwdt_pkg::WWDT_RESP_OKAY : wwdt_pkg::WWDT_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // one-cycle write strobes to the core, only with lane 0 enabled
  assign wr.ctrl_we = fire && wlane_q && (awaddr_q == wwdt_pkg::WWDT_CTRL_ADDR);
  assign wr.opt_we = fire && wlane_q && (awaddr_q == wwdt_pkg::WWDT_OPT_ADDR);
  assign wr.wdata = wdata_q;

  // ==========================================================
  // read channel
  assign arready = !rvalid;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= wwdt_pkg::WWDT_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= wwdt_pkg::WWDT_RESP_OKAY;
      unique case (araddr)
        wwdt_pkg::WWDT_CTRL_ADDR: rdata <= {24'h000000, ctrl_rd};
        wwdt_pkg::WWDT_OPT_ADDR: rdata <= {24'h000000, opt_rd};
        wwdt_pkg::WWDT_STAT_ADDR: rdata <= {24'h000000, stat_rd};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= wwdt_pkg::WWDT_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : wwdt_axil
`default_nettype wire

// ### logic/wwdt_core.sv
/*
  Watchdog counter, arming, option bits and reset pulse generation.
  Assumes halt_exec is a one-cycle pulse from the instruction decoder and
  that resetn is the system reset that this block itself helps to raise.
*/
`timescale 1ns/1ps
`default_nettype none
module wwdt_core (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic halt_exec,
  wwdt_wr_if.dst wr,
  output logic [7:0] ctrl_rd,
  output logic [7:0] opt_rd,
  output logic [7:0] stat_rd,
  output logic wdg_reset_n
);
  logic [13:0] presc_q;
  logic step;
  logic arm_q;
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic hw_wdg_q;
  logic halt_rst_q;
  logic active;
  logic roll;
  logic soft_rst;
  logic halt_rst;
  logic trig;
  logic [10:0] pulse_q;
  logic [1:0] cause_q;

  localparam logic [13:0] STEP_LAST = 14'(wwdt_pkg::WWDT_STEP_CYCLES - 1);
  localparam logic [10:0] PULSE_LEN = 11'(wwdt_pkg::WWDT_PULSE_CYCLES);

  // ==========================================================
  // prescaler, never cleared by register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      presc_q <= 14'h0000;
    end else begin
      presc_q <= step ? 14'h0000 : presc_q + 14'h0001;
    end
  end
  assign step = (presc_q == STEP_LAST);

  // ==========================================================
  // counter: free-running, a write loads it directly
  always_comb begin
    count_d = count_q;
    if (step) begin
      count_d = count_q - 7'h01;
    end
    if (wr.ctrl_we) begin
      count_d = wr.wdata[6:0];
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= wwdt_pkg::WWDT_CTRL_RESET[6:0];
    end else begin
      count_q <= count_d;
    end
  end

  // arm bit: set only by software, cleared only by reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arm_q <= 1'b0;
    end else if (wr.ctrl_we && wr.wdata[wwdt_pkg::WWDT_ARM_BIT]) begin
      arm_q <= 1'b1;
    end
  end

  // option bits, reloaded by resetn, so a watchdog reset routed back to resetn clears hw_wdg_q and sets halt_rst_q
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hw_wdg_q <= 1'b0;
      halt_rst_q <= 1'b1;
    end else if (wr.opt_we) begin
      hw_wdg_q <= wr.wdata[0];
      halt_rst_q <= wr.wdata[1];
    end
  end

  // ==========================================================
  // reset triggers
  assign active = arm_q || hw_wdg_q;
  assign roll = active && step && !wr.ctrl_we && (count_q == wwdt_pkg::WWDT_ROLL_FROM);
  // an already armed block cannot be disarmed, so a top-bit-clear write resets too
  assign soft_rst = wr.ctrl_we && (wr.wdata[wwdt_pkg::WWDT_ARM_BIT] || active)
                    && !wr.wdata[wwdt_pkg::WWDT_TOP_BIT];
  assign halt_rst = halt_exec && active && halt_rst_q;
  assign trig = roll || soft_rst || halt_rst;

  // reset pulse; the chip's reset phase adds its own cycles afterwards
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_q <= 11'h000;
      cause_q <= 2'h0;
    end else if (trig && pulse_q == 11'h000) begin
      pulse_q <= PULSE_LEN;
      cause_q <= {halt_rst, roll || soft_rst};
    end else if (pulse_q != 11'h000) begin
      pulse_q <= pulse_q - 11'h001;
    end
  end
  assign wdg_reset_n = (pulse_q == 11'h000);

  assign ctrl_rd = {arm_q, count_q};
  assign opt_rd = {6'h00, halt_rst_q, hw_wdg_q};
  assign stat_rd = {5'h00, active, cause_q};

  // ==========================================================
  // checks
  chk_step_period: assert property (@(posedge sys_clk) disable iff (!resetn)
    step |-> $past(presc_q) == 14'(STEP_LAST - 14'h0001))
    else $error("prescaler step period wrong");
  chk_arm_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    arm_q |=> arm_q)
    else $error("arm bit cleared without reset");
  chk_arm_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr.ctrl_we && wr.wdata[7] |=> arm_q)
    else $error("arm bit not set by write");
  chk_roll_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    roll && wdg_reset_n |=> !wdg_reset_n)
    else $error("rollover did not reset");
  chk_soft_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr.ctrl_we && wr.wdata[7] && !wr.wdata[6] && wdg_reset_n |=> !wdg_reset_n)
    else $error("software reset missing");
  chk_halt_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    halt_exec && arm_q && halt_rst_q && wdg_reset_n |=> !wdg_reset_n)
    else $error("halt reset missing");
  chk_count_free: assert property (@(posedge sys_clk) disable iff (!resetn)
    step && !wr.ctrl_we |=> count_q == 7'($past(count_q) - 7'h01))
    else $error("counter did not decrement");
  chk_count_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr.ctrl_we |=> count_q == $past(wr.wdata[6:0]))
    else $error("write did not load counter");
  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    !active && !wr.ctrl_we && wdg_reset_n |=> wdg_reset_n)
    else $error("reset while disarmed");
endmodule : wwdt_core
`default_nettype wire

// ### logic/wwdt_top.sv
/*
  Top of the windowed watchdog timer: AXI4-Lite register slave plus core.
  Assumes sys_clk is the 40 MHz machine-cycle clock and that the system
  reset network routes wdg_reset_n back to resetn.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - the counter steps down once every 16000 clock cycles, giving up to 64 steps.
// - when armed and the counter rolls from 40h to 3Fh, a reset pulse is driven low.
// - the counter keeps decrementing whether or not the watchdog is armed.
// - every reset leaves the watchdog disarmed and only a reset disarms it.
// - software may set the arm bit but never clear it.
// - writing the arm bit set with bit 6 clear resets at once.
// - a halt instruction while active produces a reset.
// - an option bit chooses whether halt produces that reset.
// - an option bit keeps the watchdog always active regardless of the arm bit.
// - the timeout spread of one step comes from the prescaler phase at the write.
// - the reset phase of the chip adds its own cycles after the pulse.
// - the control register holds arm in bit 7 and count in bits 6:0, resetting to 7Fh.
module wwdt_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic halt_exec,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wdg_reset_n
);
  logic [7:0] ctrl_rd;
  logic [7:0] opt_rd;
  logic [7:0] stat_rd;
  wwdt_wr_if wr ();

  // ==========================================================
  // register slave
  wwdt_axil u_axil (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .ctrl_rd(ctrl_rd),
    .opt_rd(opt_rd),
    .stat_rd(stat_rd),
    .wr(wr)
  );

  // ==========================================================
  // watchdog core
  wwdt_core u_core (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .halt_exec(halt_exec),
    .wr(wr),
    .ctrl_rd(ctrl_rd),
    .opt_rd(opt_rd),
    .stat_rd(stat_rd),
    .wdg_reset_n(wdg_reset_n)
  );
endmodule : wwdt_top
`default_nettype wire

// ### test/test_windowed_watchdog_timer.sv
/*
  Self-checking bench for the watchdog top: register bus, counter, arming,
  reset pulse, halt and hardware options.
  Assumes the reset output is observed only; the bench owns resetn.
*/
`timescale 1ns/1ps
`default_nettype none
module test_windowed_watchdog_timer;
  logic sys_clk = 1'b0, resetn = 1'b0, halt_exec = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic wdg_reset_n;
  int n_fail = 0, checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  int len;

  wwdt_top u_wwdt_top (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .halt_exec(halt_exec),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wdg_reset_n(wdg_reset_n)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    // bready stays high between transfers, so calls can follow back to back
    resp = s_axi_bresp;
    if (n >= 100) check(1'b0, 1'b1, "write answer");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    if (n >= 100) check(1'b0, 1'b1, "read answer");
  endtask : rd

  // waits up to lim cycles for the pulse, then measures its low time
  task automatic pulse(input int lim, output int low);
    int n;
    n = 0;
    low = 0;
    while (wdg_reset_n !== 1'b0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    while (wdg_reset_n === 1'b0 && low < 3000) begin
      @(posedge sys_clk);
      low++;
    end
  endtask : pulse

  task automatic halt_pulse;
    halt_exec <= 1'b1;
    @(posedge sys_clk);
    halt_exec <= 1'b0;
  endtask : halt_pulse

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'h7f, "ctrl reset");
    s_axi_wstrb <= 4'h0;
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'h80, r);
    s_axi_wstrb <= 4'h1;
    check(r, wwdt_pkg::WWDT_RESP_OKAY, "masked write okay");
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'h7f, "masked write ignored");
    rd(wwdt_pkg::WWDT_OPT_ADDR, d, r);
    check(d, 32'h02, "opt reset");
    rd(wwdt_pkg::WWDT_STAT_ADDR, d, r);
    check(d, 32'h00, "stat reset");
    rd(8'h10, d, r);
    check(d, 32'h0, "unmapped read data");
    check(r, wwdt_pkg::WWDT_RESP_SLVERR, "unmapped read");
    wr(8'h10, 8'h00, r);
    check(r, wwdt_pkg::WWDT_RESP_SLVERR, "unmapped write");
    check(wdg_reset_n, 1'b1, "no reset");
    $display("test reset values done");
  endtask : t_reset

  task automatic t_free;
    repeat (16500) @(posedge sys_clk);
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'h7e, "unarmed count step");
    halt_pulse();
    pulse(50, len);
    check(len, 0, "halt while unarmed");
    $display("test free run done");
  endtask : t_free

  task automatic t_arm;
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'h40, r);
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'h40, "load without arm");
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hff, r);
    check(r, wwdt_pkg::WWDT_RESP_OKAY, "write okay");
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'h7f, r);
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'hff, "arm not cleared");
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hc0, r);
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'hc0, "reload value");
    pulse(16100, len);
    check(len, wwdt_pkg::WWDT_PULSE_CYCLES, "rollover reset");
    do_reset();
    rd(wwdt_pkg::WWDT_CTRL_ADDR, d, r);
    check(d, 32'h7f, "disarmed by reset");
    $display("test arm and rollover done");
  endtask : t_arm

  task automatic t_soft;
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hbf, r);
    pulse(5, len);
    check(len, wwdt_pkg::WWDT_PULSE_CYCLES, "software reset");
    rd(wwdt_pkg::WWDT_STAT_ADDR, d, r);
    check(d, 32'h05, "software reset cause");
    do_reset();
    $display("test software reset done");
  endtask : t_soft

  task automatic t_halt;
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hff, r);
    halt_pulse();
    pulse(5, len);
    check(len, wwdt_pkg::WWDT_PULSE_CYCLES, "halt reset");
    rd(wwdt_pkg::WWDT_STAT_ADDR, d, r);
    check(d, 32'h06, "halt reset cause");
    do_reset();
    wr(wwdt_pkg::WWDT_OPT_ADDR, 8'h00, r);
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hff, r);
    halt_pulse();
    pulse(50, len);
    check(len, 0, "halt reset disabled");
    do_reset();
    $display("test halt done");
  endtask : t_halt

  task automatic t_hw;
    wr(wwdt_pkg::WWDT_OPT_ADDR, 8'h01, r);
    rd(wwdt_pkg::WWDT_STAT_ADDR, d, r);
    check(d[2], 1'b1, "hardware active");
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'h3f, r);
    pulse(5, len);
    check(len, wwdt_pkg::WWDT_PULSE_CYCLES, "hardware soft reset");
    do_reset();
    $display("test hardware option done");
  endtask : t_hw

  // refreshes well inside one step keep it quiet; a last short load must fire
  task automatic t_refresh;
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hc1, r);
    repeat (2) begin
      pulse(12000, len);
      check(len, 0, "refreshed watchdog fired");
      wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hc1, r);
    end
    wr(wwdt_pkg::WWDT_CTRL_ADDR, 8'hc0, r);
    pulse(16100, len);
    check(len, wwdt_pkg::WWDT_PULSE_CYCLES, "reset after refresh stops");
    $display("test refresh done");
  endtask : t_refresh

  // ==========================================================
  // main sequence and watchdog
  initial begin
    do_reset();
    t_reset();
    t_free();
    t_arm();
    t_soft();
    t_halt();
    t_hw();
    t_refresh();
    end_sim();
  end

  initial begin
    #2400000;
    n_fail++;
    end_sim();
  end
endmodule : test_windowed_watchdog_timer
`default_nettype wire
